// file: design/crc_scan_pkg.sv
// package of constants for the crc engine with program memory scanner
// ============================================================
// Overview of operation
// - word length field plus one sets shifts
// - augment zeros and bit order selectable
// - crc run bit starts the shifter
// - write high byte, low byte starts shift
// - scanner feeds flash words when crc ready
// - busy holds until accumulator result valid
// - enable clear resets engine, keeps registers
// - scan from start address to end address
// - enable or run clear aborts, sets invalid
// - scanner waits for crc ready first
// - end address stops scan, sets done flag
// - software clearing scan run ends scan, except in an unpaused burst
// - done flag on end address or bad address, sticky
// - burst mode stalls cpu until hardware end
// - concurrent mode stalls cpu per access
// - triggered mode starts on trigger rising edge
// - peek mode uses only idle cpu cycles
// - burst yield mode pauses on interrupt
// - non-yield mode keeps scanning through interrupt
package crc_scan_pkg;
    localparam int ADDR_W = 12;
    localparam int FA_W   = 21;
    // register byte offsets on the apb bus
    localparam logic [ADDR_W-1:0] OFS_CTRL   = 12'h000;
    localparam logic [ADDR_W-1:0] OFS_DATA   = 12'h004;
    localparam logic [ADDR_W-1:0] OFS_ACC    = 12'h008;
    localparam logic [ADDR_W-1:0] OFS_POLY   = 12'h00C;
    localparam logic [ADDR_W-1:0] OFS_SCAN   = 12'h010;
    localparam logic [ADDR_W-1:0] OFS_START  = 12'h014;
    localparam logic [ADDR_W-1:0] OFS_END    = 12'h018;
    localparam logic [ADDR_W-1:0] OFS_TRIG   = 12'h01C;
    localparam logic [ADDR_W-1:0] OFS_FLAGS  = 12'h020;
    // control register field positions
    localparam int C_EN = 0;
    localparam int C_RUN = 1;
    localparam int C_AUG = 2;
    localparam int C_ORD = 3;
    localparam int C_BUSY = 4;
    localparam int C_FULL = 5;
    localparam int C_WL = 8;
    localparam int C_PL = 12;
    // scan control field positions
    localparam int S_EN = 0;
    localparam int S_RUN = 1;
    localparam int S_INV = 2;
    localparam int S_YLD = 3;
    localparam int S_MODE = 4;
    // flag register field positions
    localparam int F_CRC_DONE = 0;
    localparam int F_SCAN_DONE = 1;
    localparam int F_SCAN_IE = 2;
    // scan modes
    localparam logic [1:0] MODE_CONC  = 2'h0;
    localparam logic [1:0] MODE_BURST = 2'h1;
    localparam logic [1:0] MODE_PEEK  = 2'h2;
    localparam logic [1:0] MODE_TRIG  = 2'h3;
    localparam logic [4:0] AUG_SHIFTS_ONE = 5'h01;
endpackage : crc_scan_pkg

// file: design/crc_shifter.sv
// crc shift engine: one bit per clock from a holding word
`timescale 1ns/1ps
module crc_shifter (
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    input  wire logic        clr,
    input  wire logic        run,
    input  wire logic [3:0]  word_len,
    input  wire logic [3:0]  poly_len,
    input  wire logic        aug,
    input  wire logic        lsb_first,
    input  wire logic [15:0] poly,
    input  wire logic        load,
    input  wire logic [15:0] word,
    input  wire logic        acc_wr,
    input  wire logic [15:0] acc_wdata,
    output logic [15:0]      acc,
    output logic             full,
    output logic             busy
);
    import crc_scan_pkg::*;
    typedef struct packed {
        logic [15:0] acc;
        logic [15:0] hold;
        logic        hold_v;
        logic [15:0] sh;
        logic [4:0]  cnt;
        logic        busy;
    } sh_state_type;
    sh_state_type q, d;
    logic [15:0] top_mask;
    logic        din;
    logic        fb;
    // shift one bit; augmented mode folds the data bit into the
    // feedback: same result as trailing zeros, without extra steps
    always_comb begin
        d = q;
        top_mask = 16'h0001 << poly_len;
        din = lsb_first ? q.sh[0] : q.sh[word_len];
        fb = ((q.acc & top_mask) != 16'h0000) ^ (aug && din);
        if (q.cnt != 5'h00) begin
            d.acc = ({q.acc[14:0], din && !aug}
                     ^ (fb ? (poly | 16'h0001) : 16'h0000))
                    & ((top_mask << 1) - 16'h0001);
            d.sh = lsb_first ? (q.sh >> 1) : (q.sh << 1);
            d.cnt = q.cnt - 5'h01;
        end else if (run && q.hold_v) begin
            d.sh = q.hold;
            d.hold_v = 1'b0;
            d.cnt = {1'b0, word_len} + AUG_SHIFTS_ONE;
        end
        if (load) begin
            d.hold = word;
            d.hold_v = 1'b1;
        end
        if (acc_wr) d.acc = acc_wdata;
        // busy covers queued and in-flight work
        d.busy = d.hold_v || (d.cnt != 5'h00);
        // disable wipes the engine but the visible accumulator stays
        if (clr) begin
            d = '0;
            d.acc = acc_wr ? acc_wdata : q.acc;
        end
    end
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) q <= '0;
        else q <= d;
    end
    assign acc = q.acc;
    assign full = q.hold_v;
    assign busy = q.busy;
endmodule : crc_shifter

// file: design/crc_memory_scanner.sv
// crc engine top with apb registers and flash memory scanner
//
// Added by the designer: the register offsets and the APB slave port.
`timescale 1ns/1ps
module crc_memory_scanner #(
    parameter int FA_WIDTH = 21
) (
    input  wire logic                          core_clk,
    input  wire logic                          rst_n,
    input  wire logic                          psel,
    input  wire logic                          penable,
    input  wire logic                          pwrite,
    input  wire logic [crc_scan_pkg::ADDR_W-1:0] paddr,
    input  wire logic [31:0]                   pwdata,
    output logic [31:0]                        prdata,
    output logic                               pready,
    output logic                               pslverr,
    input  wire logic [7:0]                    trig_in,
    input  wire logic                          irq_active,
    input  wire logic                          cpu_needs_flash,
    output logic                               flash_req,
    output logic [FA_WIDTH-1:0]                flash_addr,
    input  wire logic                          flash_ack,
    input  wire logic [15:0]                   flash_data,
    input  wire logic                          flash_bad_addr,
    output logic                               cpu_stall
);
    import crc_scan_pkg::*;
    typedef enum logic [1:0] {S_IDLE, S_WAIT, S_FETCH, S_LOAD} scan_st_type;
    typedef struct packed {
        logic [15:0]         ctrl;
        logic [15:0]         data;
        logic [15:0]         poly;
        logic [7:0]          scan;
        logic [FA_WIDTH-1:0] start_a;
        logic [FA_WIDTH-1:0] end_a;
        logic [FA_WIDTH-1:0] cur_a;
        logic [2:0]          trig_sel;
        logic [2:0]          flags;
        scan_st_type         st;
        logic                last;
        logic                trig_prev;
        logic                armed;
        logic [1:0]          trig_sync0;
        logic [1:0]          trig_sync1;
        logic                irq_s0;
        logic                irq_s1;
        logic                cpu_s0;
        logic                cpu_s1;
        logic [31:0]         prdata;
        logic                pready;
        logic                pslverr;
        logic                freq;
        logic                stall;
    } top_state_type;
    top_state_type q, d;
    logic [15:0] acc;
    logic        full;
    logic        busy;
    logic        wr_en;
    logic        rd_en;
    logic        load;
    logic [15:0] word;
    logic        acc_wr;
    logic        clr;
    logic        trig_now;
    logic        paused;
    logic        busy_prev_q;
    logic [1:0]  mode;
    logic        yield;

    // ========================================================
    // crc engine
    crc_shifter u_shifter (
        .core_clk  (core_clk),
        .rst_n     (rst_n),
        .clr       (clr),
        .run       (q.ctrl[C_RUN]),
        .word_len  (q.ctrl[C_WL +: 4]),
        .poly_len  (q.ctrl[C_PL +: 4]),
        .aug       (q.ctrl[C_AUG]),
        .lsb_first (q.ctrl[C_ORD]),
        .poly      (q.poly),
        .load      (load),
        .word      (word),
        .acc_wr    (acc_wr),
        .acc_wdata (pwdata[15:0]),
        .acc       (acc),
        .full      (full),
        .busy      (busy)
    );

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) busy_prev_q <= 1'b0;
        else busy_prev_q <= busy;
    end

    // ========================================================
    // apb slave, registers and scanner
    always_comb begin
        d = q;
        mode = q.scan[S_MODE +: 2];
        yield = q.scan[S_YLD];
        // yielding to interrupts suspends all but peek
        paused = yield && q.irq_s1 && mode != MODE_PEEK;
        wr_en = psel && penable && pwrite && !q.pready;
        rd_en = psel && !penable;
        load = 1'b0;
        word = q.data;
        acc_wr = 1'b0;
        // two-flop synchronisers for pin-domain inputs
        d.trig_sync0 = {d.trig_sync0[0], 1'b0};
        d.trig_sync0[0] = trig_in[q.trig_sel];
        d.trig_sync1 = {q.trig_sync1[0], q.trig_sync0[0]};
        d.irq_s0 = irq_active;
        d.irq_s1 = q.irq_s0;
        d.cpu_s0 = cpu_needs_flash;
        d.cpu_s1 = q.cpu_s0;
        trig_now = q.trig_sync1[0] && !q.trig_sync1[1];
        // one-wait apb: access phase answered on its second cycle
        d.pready = psel && penable && !q.pready;
        d.pslverr = 1'b0;
        if (wr_en) begin
            unique case (paddr)
                OFS_CTRL: d.ctrl = {pwdata[15:6], 2'b00, pwdata[3:0]};
                OFS_DATA: begin
                    // high byte staged; low byte write launches word
                    d.data = pwdata[15:0];
                    load = pwdata[16] || !q.ctrl[C_RUN] ? 1'b0 : 1'b1;
                    word = pwdata[15:0];
                end
                OFS_ACC: acc_wr = 1'b1;
                OFS_POLY: d.poly = {pwdata[15:1], 1'b0};
                OFS_SCAN: begin
                    d.scan[S_EN] = pwdata[S_EN];
                    d.scan[S_YLD] = pwdata[S_YLD];
                    d.scan[S_MODE +: 2] = pwdata[S_MODE +: 2];
                    d.scan[S_INV] = q.scan[S_INV] && !pwdata[S_INV];
                    // software cannot stop an unpaused burst: cpu is stalled
                    if (!(q.st != S_IDLE && mode == MODE_BURST && !paused))
                        d.scan[S_RUN] = pwdata[S_RUN];
                end
                OFS_START: d.start_a = pwdata[FA_WIDTH-1:0];
                OFS_END: d.end_a = pwdata[FA_WIDTH-1:0];
                OFS_TRIG: d.trig_sel = pwdata[2:0];
                OFS_FLAGS: begin
                    d.flags[F_CRC_DONE] = q.flags[F_CRC_DONE] && !pwdata[0];
                    d.flags[F_SCAN_DONE] = q.flags[F_SCAN_DONE] && !pwdata[1];
                    d.flags[F_SCAN_IE] = pwdata[F_SCAN_IE];
                end
                default: d.pslverr = 1'b1;
            endcase
        end else if (psel && penable && !q.pready) begin
            unique case (paddr)
                OFS_CTRL: d.prdata = {16'h0000, q.ctrl[15:6], full, busy,
                                      q.ctrl[3:0]};
                OFS_DATA: d.prdata = {16'h0000, q.data};
                OFS_ACC: d.prdata = {16'h0000, acc};
                OFS_POLY: d.prdata = {16'h0000, q.poly};
                // a suspended scan reads as stopped until it resumes
                OFS_SCAN: d.prdata = {24'h000000, q.scan[7:S_INV],
                                      q.scan[S_RUN] && !paused,
                                      q.scan[S_EN]};
                OFS_START: d.prdata = 32'(q.cur_a);
                OFS_END: d.prdata = 32'(q.end_a);
                OFS_TRIG: d.prdata = {29'h00000000, q.trig_sel};
                OFS_FLAGS: d.prdata = {29'h00000000, q.flags};
                default: begin
                    d.prdata = 32'h00000000;
                    d.pslverr = 1'b1;
                end
            endcase
        end
        // crc done flag on busy fall; set beats clear
        if (busy_prev_q && !busy) d.flags[F_CRC_DONE] = 1'b1;
        d.freq = 1'b0;
        d.stall = 1'b0;
        unique case (q.st)
            S_IDLE: begin
                d.cur_a = d.start_a;
                d.armed = 1'b0;
                if (q.scan[S_RUN] && q.scan[S_EN])
                    d.st = S_WAIT;
            end
            S_WAIT: begin
                if (trig_now) d.armed = 1'b1;
                // each word only after crc can accept it
                if (!full && !paused && (mode != MODE_TRIG || q.armed
                                       || trig_now)) begin
                    d.armed = 1'b1;
                    if (mode != MODE_PEEK || !q.cpu_s1) begin
                        d.st = S_FETCH;
                        d.freq = 1'b1;
                        d.stall = mode != MODE_PEEK;
                    end
                end
                if (mode == MODE_BURST) d.stall = !paused;
            end
            S_FETCH: begin
                d.freq = 1'b1;
                d.stall = mode != MODE_PEEK;
                if (flash_ack) begin
                    d.freq = 1'b0;
                    d.data = flash_data;
                    d.last = flash_bad_addr || q.cur_a == q.end_a;
                    d.st = flash_bad_addr ? S_IDLE : S_LOAD;
                    if (flash_bad_addr) begin
                        d.scan[S_RUN] = 1'b0;
                        d.flags[F_SCAN_DONE] = 1'b1;
                    end
                end
            end
            S_LOAD: begin
                load = 1'b1;
                word = q.data;
                d.cur_a = q.cur_a + FA_WIDTH'(1);
                d.stall = mode == MODE_BURST;
                if (q.last) begin
                    d.st = S_IDLE;
                    d.scan[S_RUN] = 1'b0;
                    d.flags[F_SCAN_DONE] = 1'b1;
                end else d.st = S_WAIT;
            end
            default: d.st = S_IDLE;
        endcase
        // software stop ends scan without done flag
        if (!d.scan[S_RUN] && q.st != S_IDLE && q.st != S_FETCH) begin
            d.st = S_IDLE;
            d.freq = 1'b0;
            d.stall = 1'b0;
        end
        // abort on enable or crc run loss
        if (q.scan[S_RUN] && (!q.ctrl[C_EN] || !q.ctrl[C_RUN])) begin
            d.scan[S_RUN] = 1'b0;
            d.scan[S_INV] = 1'b1;
            d.st = S_IDLE;
            d.freq = 1'b0;
            d.stall = 1'b0;
        end
        // scanner disable clears only on its falling write, so manual
        // entry still works with the scanner switched off
        clr = !q.ctrl[C_EN]
              || (wr_en && paddr == OFS_SCAN && q.scan[S_EN]
                  && !pwdata[S_EN]);
        if (clr) begin
            d.st = S_IDLE;
            d.freq = 1'b0;
            d.stall = 1'b0;
            load = 1'b0;
        end
        d.prdata = (psel && penable && !q.pready) ? d.prdata : 32'h00000000;
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) q <= '0;
        else q <= d;
    end

    assign prdata = q.prdata;
    assign pready = q.pready;
    assign pslverr = q.pslverr;
    assign flash_req = q.freq;
    assign flash_addr = q.cur_a;
    assign cpu_stall = q.stall;

    // ========================================================
    // assertions
    property p_abort;
        @(posedge core_clk) disable iff (!rst_n)
        (q.scan[S_RUN] && !q.ctrl[C_RUN]) |=> (!q.scan[S_RUN] && q.scan[S_INV]);
    endproperty
    a_abort: assert property (p_abort) else $error("abort missed");
    property p_idle_no_req;
        @(posedge core_clk) disable iff (!rst_n)
        (q.st == S_IDLE) |-> !flash_req;
    endproperty
    a_idle_no_req: assert property (p_idle_no_req)
        else $error("flash access while idle");
    property p_done;
        @(posedge core_clk) disable iff (!rst_n)
        (q.st == S_LOAD && q.last && !clr && q.ctrl[C_RUN])
            |=> (q.flags[F_SCAN_DONE] && !q.scan[S_RUN]);
    endproperty
    a_done: assert property (p_done) else $error("no done flag");
    property p_done_sticky;
        @(posedge core_clk) disable iff (!rst_n)
        (q.flags[F_SCAN_DONE] && !(wr_en && paddr == OFS_FLAGS))
            |=> q.flags[F_SCAN_DONE];
    endproperty
    a_done_sticky: assert property (p_done_sticky)
        else $error("done flag lost");
    property p_wait_full;
        @(posedge core_clk) disable iff (!rst_n)
        (q.st == S_WAIT && full) |=> (q.st != S_FETCH);
    endproperty
    a_wait_full: assert property (p_wait_full)
        else $error("fetch while crc full");
    property p_peek;
        @(posedge core_clk) disable iff (!rst_n)
        (mode == MODE_PEEK) |-> !cpu_stall;
    endproperty
    a_peek: assert property (p_peek) else $error("peek stalled cpu");
    property p_clr;
        @(posedge core_clk) disable iff (!rst_n)
        $fell(q.scan[S_EN]) |-> (q.st == S_IDLE && !full);
    endproperty
    a_clr: assert property (p_clr) else $error("disable left state");
    property p_burst_stall;
        @(posedge core_clk) disable iff (!rst_n)
        (q.st == S_WAIT && mode == MODE_BURST && !paused && !clr
            && q.scan[S_RUN] && q.ctrl[C_RUN] && q.ctrl[C_EN])
            |=> cpu_stall;
    endproperty
    a_burst_stall: assert property (p_burst_stall)
        else $error("burst not stalling");
    c_scan_done: cover property (@(posedge core_clk) $rose(q.flags[F_SCAN_DONE]));
    c_abort: cover property (@(posedge core_clk) $rose(q.scan[S_INV]));
    c_busy_fall: cover property (@(posedge core_clk) $fell(busy));
endmodule : crc_memory_scanner

// file: sim/flash_model.sv
// flash and arbiter stand-in answering scanner word reads
`timescale 1ns/1ps
module flash_model #(
    parameter int FA_WIDTH = 21,
    parameter int BAD_FROM = 256
) (
    input  wire logic                core_clk,
    input  wire logic                rst_n,
    input  wire logic [7:0]          lat,
    input  wire logic                flash_req,
    input  wire logic [FA_WIDTH-1:0] flash_addr,
    output logic                     flash_ack,
    output logic [15:0]              flash_data,
    output logic                     flash_bad_addr
);
    logic [7:0] wait_q;
    // ============================================================
    // one word per request after lat cycles; lines scramble off ack
    // so a scanner that samples late reads inverted, wrong data
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            wait_q         <= 8'h00;
            flash_ack      <= 1'b0;
            flash_data     <= 16'h0000;
            flash_bad_addr <= 1'b0;
        end else if (flash_req && !flash_ack && wait_q >= lat) begin
            wait_q         <= 8'h00;
            flash_ack      <= 1'b1;
            flash_data     <= 16'hC300 ^ flash_addr[15:0];
            flash_bad_addr <= flash_addr >= FA_WIDTH'(BAD_FROM);
        end else begin
            wait_q         <= (flash_req && !flash_ack) ? wait_q + 8'h01
                                                        : 8'h00;
            flash_ack      <= 1'b0;
            flash_data     <= ~flash_data;
            flash_bad_addr <= ~flash_bad_addr;
        end
    end
endmodule : flash_model

// file: sim/crc_memory_scanner_tb.sv
// self-checking bench for the crc engine with memory scanner
`timescale 1ns/1ps
module crc_memory_scanner_tb;
    import crc_scan_pkg::*;
    localparam int BAD = 256;
    logic              core_clk = 1'b0;
    logic              rst_n = 1'b0;
    logic              psel = 1'b0;
    logic              penable = 1'b0;
    logic              pwrite = 1'b0;
    logic [ADDR_W-1:0] paddr = '0;
    logic [31:0]       pwdata = '0;
    logic [31:0]       prdata;
    logic              pready;
    logic              pslverr;
    logic [7:0]        trig_in = 8'h00;
    logic              irq_active = 1'b0;
    logic              cpu_needs_flash = 1'b0;
    logic              flash_req;
    logic [20:0]       flash_addr;
    logic              flash_ack;
    logic [15:0]       flash_data;
    logic              flash_bad_addr;
    logic              cpu_stall;
    logic [7:0]        lat = 8'h03;
    logic [20:0]       first_a;
    logic [20:0]       last_a;
    logic [31:0]       r;
    logic              e;
    int                failures = 0;
    int                n_tests = 0;
    int                nacc = 0;
    int                lo_run = 0;
    int                lo_tot = 0;

    crc_memory_scanner #(.FA_WIDTH(21)) crc_memory_scanner_i (
        .core_clk(core_clk), .rst_n(rst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .trig_in(trig_in), .irq_active(irq_active),
        .cpu_needs_flash(cpu_needs_flash), .flash_req(flash_req),
        .flash_addr(flash_addr), .flash_ack(flash_ack),
        .flash_data(flash_data), .flash_bad_addr(flash_bad_addr),
        .cpu_stall(cpu_stall));
    flash_model #(.FA_WIDTH(21), .BAD_FROM(BAD)) flash_model_i (
        .core_clk(core_clk), .rst_n(rst_n), .lat(lat),
        .flash_req(flash_req), .flash_addr(flash_addr),
        .flash_ack(flash_ack), .flash_data(flash_data),
        .flash_bad_addr(flash_bad_addr));

    // ============================================================
    // clock, and a tally of accesses and cpu run gaps between them
    always #10 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        if (!cpu_stall) lo_run++;
        if (flash_req && flash_ack) begin
            if (nacc == 0) first_a = flash_addr;
            else lo_tot += lo_run;
            last_a = flash_addr;
            lo_run = 0;
            nacc++;
        end
    end

    // ============================================================
    // compare, bus cycles and polling
    task automatic chk(input string nm, input logic [31:0] got, exp);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic apb(input logic w, input int a, input logic [31:0] d);
        int n;
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a[ADDR_W-1:0];
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (pready !== 1'b1 && n < 40);
        chk("pready", pready, 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wr(input int a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr
    task automatic rd(input int a);
        apb(1'b0, a, 32'h0);
    endtask : rd
    // bounded wait; polling trades bus traffic for no timing guess
    task automatic poll(input int a, input int b, input logic v);
        int n;
        n = 0;
        do begin
            rd(a);
            n++;
        end while (r[b] !== v && n < 3000);
        chk("poll", r[b], v);
    endtask : poll

    // ============================================================
    // scan setup, launch and completion
    task automatic go(input logic [1:0] md, input logic y, input int s, en);
        wr(OFS_CTRL, 32'h0);
        wr(OFS_SCAN, 32'h4);
        wr(OFS_POLY, 32'h8004);
        wr(OFS_CTRL, 32'hFF03);
        wr(OFS_START, s);
        wr(OFS_END, en);
        wr(OFS_FLAGS, 32'h2);
        wr(OFS_SCAN, {26'h0, md, y, 3'h1});
        nacc = 0;
        lo_tot = 0;
        wr(OFS_SCAN, {26'h0, md, y, 3'h3});
    endtask : go
    task automatic done_ok(input int s, en);
        repeat (10) @(posedge core_clk);
        poll(OFS_SCAN, S_RUN, 1'b0);
        rd(OFS_FLAGS);
        chk("done", r[F_SCAN_DONE], 1'b1);
        chk("first", first_a, s);
        chk("last", last_a, en);
    endtask : done_ok

    // ============================================================
    // scenarios
    task automatic t_reset();
        repeat (20) @(posedge core_clk);
        chk("req", flash_req, 1'b0);
        rd(OFS_SCAN);
        chk("run", r[S_RUN], 1'b0);
        rd(12'h0FC);
        chk("err", e, 1'b1);
        chk("rd0", r, 32'h0);
    endtask : t_reset
    task automatic t_crc(input logic w, input logic o, input logic [15:0] x);
        logic [31:0] d;
        logic [7:0]  b;
        logic [7:0]  hb;
        d = 32'h55667788;
        wr(OFS_CTRL, 32'h0);
        wr(OFS_ACC, 32'h0);
        wr(OFS_POLY, 32'h8005);
        rd(OFS_POLY);
        chk("poly", r, 32'h8004);
        wr(OFS_CTRL, {16'h0, 4'hF, w ? 4'hF : 4'h7, 4'h0, o, 3'h7});
        for (int i = 0; i < 4; i++) begin
            b = d[31-8*i -: 8];
            if (!w || i % 2 == 0) poll(OFS_CTRL, C_FULL, 1'b0);
            if (w && i % 2 == 0) wr(OFS_DATA, {15'h0, 1'b1, b, 8'h00});
            else wr(OFS_DATA, {16'h0, w ? hb : 8'h00, b});
            hb = b;
        end
        poll(OFS_CTRL, C_BUSY, 1'b0);
        rd(OFS_ACC);
        chk("acc", r[15:0], x);
        wr(OFS_CTRL, 32'h0);
        rd(OFS_ACC);
        chk("kept", r[15:0], x);
    endtask : t_crc
    task automatic t_burst();
        go(MODE_BURST, 1'b0, 'h10, 'h17);
        wr(OFS_SCAN, {26'h0, MODE_BURST, 1'b0, 3'h1});
        done_ok('h10, 'h17);
        chk("gap", lo_tot, 0);
    endtask : t_burst
    task automatic t_conc(input logic y);
        int n;
        go(MODE_CONC, y, 'h20, 'h27);
        irq_active <= 1'b1;
        repeat (10) @(posedge core_clk);
        n = nacc;
        repeat (60) @(posedge core_clk);
        chk("irq", nacc == n, y);
        irq_active <= 1'b0;
        done_ok('h20, 'h27);
        chk("cpu", lo_tot > 0, 1'b1);
    endtask : t_conc
    task automatic t_yield();
        int n;
        go(MODE_BURST, 1'b1, 'h40, 'h4F);
        repeat (30) @(posedge core_clk);
        irq_active <= 1'b1;
        repeat (10) @(posedge core_clk);
        n = nacc;
        rd(OFS_SCAN);
        chk("run0", {r[S_RUN], cpu_stall}, 2'b00);
        repeat (40) @(posedge core_clk);
        chk("pause", nacc, n);
        irq_active <= 1'b0;
        done_ok('h40, 'h4F);
    endtask : t_yield
    task automatic t_wait(input logic [1:0] md, input int s);
        go(md, 1'b0, s, s + 3);
        repeat (40) @(posedge core_clk);
        trig_in <= 8'h04;
        repeat (40) @(posedge core_clk);
        chk("held", nacc, 0);
        trig_in <= 8'h0C;
        cpu_needs_flash <= 1'b0;
        done_ok(s, s + 3);
    endtask : t_wait
    task automatic t_stop(input logic ab);
        int n;
        lat <= 8'd20;
        go(MODE_CONC, 1'b0, 'h0, 'hFF);
        repeat (60) @(posedge core_clk);
        if (ab) wr(OFS_CTRL, 32'hFF01);
        else wr(OFS_SCAN, {26'h0, MODE_CONC, 1'b0, 3'h1});
        repeat (40) @(posedge core_clk);
        n = nacc;
        repeat (60) @(posedge core_clk);
        chk("stop", nacc, n);
        rd(OFS_SCAN);
        chk("inv", r[S_INV:S_RUN], {ab, 1'b0});
        rd(OFS_FLAGS);
        chk("nodone", r[F_SCAN_DONE], 1'b0);
        lat <= 8'd2;
    endtask : t_stop

    // ============================================================
    // verdict, watchdog and main sequence
    task automatic conclude();
        $display("checks %0d failures %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : conclude
    initial begin
        repeat (90000) @(posedge core_clk);
        failures++;
        conclude();
    end
    initial begin
        repeat (2) @(posedge core_clk);
        rst_n <= 1'b1;
        t_reset();
        t_crc(1'b0, 1'b0, 16'h32D6);
        t_crc(1'b0, 1'b1, 16'h6BA2);
        t_crc(1'b1, 1'b0, 16'h32D6);
        t_burst();
        t_conc(1'b0);
        t_conc(1'b1);
        t_yield();
        wr(OFS_TRIG, 32'h3);
        t_wait(MODE_TRIG, 'h30);
        cpu_needs_flash <= 1'b1;
        t_wait(MODE_PEEK, 'h50);
        t_stop(1'b0);
        t_stop(1'b1);
        go(MODE_CONC, 1'b0, BAD - 2, BAD + 8);
        done_ok(BAD - 2, BAD);
        conclude();
    end
endmodule : crc_memory_scanner_tb
